// *** hdl/cacw_chan.v ***
// One capture/compare module: compare, capture and pin output logic
`timescale 1ns/100ps
`default_nettype none
`include "cacw_regs.vh"

module cacw_chan (
	// Clock and reset
	input  wire        mclk,
	input  wire        resetn,
	// Counter state
	input  wire        moved,
	input  wire [15:0] cnt,
	input  wire [10:0] mask,
	// Configuration
	input  wire [7:0]  mode,
	input  wire [15:0] cmp,
	// Pin
	input  wire        pin_in,
	output reg         pin_out,
	output wire        pin_oe,
	// Events
	output wire        match,
	output wire        capture,
	output wire        freq_step
);

	wire ecom  = mode[`CACW_MD_ECOM];
	wire tog   = mode[`CACW_MD_TOG];
	wire pwm   = mode[`CACW_MD_PWM];
	wire freq  = tog & pwm;
	wire pwmn  = pwm & ~tog & ~mode[`CACW_MD_PWM16];
	wire p16   = pwm & ~tog & mode[`CACW_MD_PWM16];
	wire [10:0] cnt_n = cnt[10:0] & mask;
	wire [10:0] cmp_n = cmp[10:0] & mask;
	wire eq16  = (cnt == cmp);
	wire eq8   = (cnt[7:0] == cmp[7:0]);
	wire eqn   = (cnt_n == cmp_n);
	wire eq    = freq ? eq8 : (pwmn ? eqn : eq16);
	wire hit   = moved & ecom & eq;
	reg  pin_prev_r;
	wire rise  = pin_in & ~pin_prev_r;
	wire fall  = ~pin_in & pin_prev_r;

	assign match     = hit & mode[`CACW_MD_MAT];
	assign freq_step = hit & freq;
	assign capture   = ~pwm & ~tog &
		((mode[`CACW_MD_CAPP] & rise) | (mode[`CACW_MD_CAPN] & fall));
	assign pin_oe    = pwm | tog;

	// ****************************************************************
	// Pin output
	// ****************************************************************
	always @(posedge mclk) begin
		if (!resetn) begin
			pin_out    <= 1'b0;
			pin_prev_r <= 1'b0;
		end else begin
			pin_prev_r <= pin_in;
			if (pwmn)
				pin_out <= ecom & (cnt_n < cmp_n);
			else if (p16)
				pin_out <= ecom & (cnt < cmp);
			else if (tog & hit)
				pin_out <= ~pin_out;
		end
	end

endmodule
`default_nettype wire

// *** hdl/cacw_regs.vh ***
// Register map, field positions and constants of the counter array block
`ifndef CACW_REGS_VH
`define CACW_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CACW_ADDR_CTRL      8'h00
`define CACW_ADDR_AMODE     8'h04
`define CACW_ADDR_PWM       8'h08
`define CACW_ADDR_CNT_L     8'h0c
`define CACW_ADDR_CNT_H     8'h10
`define CACW_REGION_MODE    3'h1
`define CACW_REGION_LOW     3'h2
`define CACW_REGION_HIGH    3'h3

// ****************************************************************
// Field positions
// ****************************************************************
`define CACW_CTRL_CF        7
`define CACW_CTRL_CR        6
`define CACW_AM_IDLE        7
`define CACW_AM_WDT         6
`define CACW_AM_CPS_HI      3
`define CACW_AM_CPS_LO      1
`define CACW_AM_ECF         0
`define CACW_PWM_ARSEL      7
`define CACW_PWM_ECOV       6
`define CACW_PWM_COVF       5
`define CACW_PWM_CL_HI      1
`define CACW_PWM_CL_LO      0
`define CACW_MD_PWM16       7
`define CACW_MD_ECOM        6
`define CACW_MD_CAPP        5
`define CACW_MD_CAPN        4
`define CACW_MD_MAT         3
`define CACW_MD_TOG         2
`define CACW_MD_PWM         1
`define CACW_MD_ECCF        0

// ****************************************************************
// Reset values and fixed codes
// ****************************************************************
`define CACW_WDT_RESET      1'b1
`define CACW_WDT_MOD        5
`define CACW_WDT_MODE_MASK  8'h49
`define CACW_CPS_DIV12      3'h0
`define CACW_CPS_DIV4       3'h1
`define CACW_CPS_TMR        3'h2
`define CACW_CPS_EXT        3'h3
`define CACW_CPS_SYS        3'h4
`define CACW_DIV12_LAST     4'hb
`define CACW_DIV4_LAST      2'h3
`define CACW_CL_8           2'h0
`define CACW_CL_9           2'h1
`define CACW_CL_10          2'h2
`define CACW_MASK_8         11'h0ff
`define CACW_MASK_9         11'h1ff
`define CACW_MASK_10        11'h3ff
`define CACW_MASK_11        11'h7ff
`define CACW_CNT_MAX        16'hffff

`endif

// *** hdl/cacw_top.v ***
// Counter array with capture/compare modules, PWM and watchdog
// Summary of operation
// - Mode bits plus shared PWM field pick timer, HSO, frequency or PWM.
// - Cycle-length field 00..11 gives 8..11-bit PWM, shared by all.
// - 16-bit PWM needs top mode bit 1; 8-11 bit PWM needs it 0.
// - Comparator enable 0: no pin toggle, PWM output stuck low.
// - Interrupt enable passes module flag onto the interrupt output.
// - Overflow interrupt follows the 8th..11th counter bit per cycle length.
// - Select bit routes byte addresses to compare or auto-reload register.
// - Match enable lets a comparator match set the module flag.
// - Capture mode copies the counter into the 16-bit module register.
// - Edge bits pick rising, falling or both edges for capture.
// - Capture sets flag; only software clears it.
// - Watchdog uses module 5: high byte compared, low byte is offset.
// - Watchdog is enabled out of every reset.
// - Watchdog on: counter forced running, counter writes ignored.
// - Watchdog on: clock select and idle-stop bits frozen.
// - Watchdog on: module 5 forced to timer, mode writes ignored.
// - Watchdog on: run bit writes do not stop counter; reads stored value.
// - Watchdog on: module 5 high byte equal counter high byte resets.
// - Watchdog on: writing module 5 high byte reloads it with counter high plus offset.
`timescale 1ns/100ps
`default_nettype none
`include "cacw_regs.vh"

module cacw_top #(
	parameter NMOD = 6
) (
	// Clock and reset
	input  wire            mclk,
	input  wire            resetn,
	// Avalon-MM slave
	input  wire [7:0]      address,
	input  wire            read,
	input  wire            write,
	input  wire [31:0]     writedata,
	input  wire [3:0]      byteenable,
	output wire [31:0]     readdata,
	output wire            waitrequest,
	// Counter clock sources and idle
	input  wire            timer_ovf_tick,
	input  wire            ext_clk_in,
	input  wire            slow_tick,
	input  wire            cpu_idle,
	// Module pins
	input  wire [NMOD-1:0] module_pin_in,
	output wire [NMOD-1:0] module_pin_out,
	output wire [NMOD-1:0] module_pin_oe,
	// Events out
	output wire            counter_array_irq,
	output reg             watchdog_reset
);

	// ****************************************************************
	// Bus handshake
	// ****************************************************************
	reg         ack_r;
	reg  [7:0]  rdata_r;
	reg  [7:0]  rd_mux;
	wire        req     = read | write;
	wire        wr_go   = write & ack_r & byteenable[0];
	wire [7:0]  wdata   = writedata[7:0];
	wire [2:0]  region  = address[7:5];
	wire [2:0]  idx     = address[4:2];
	wire        in_mods = (address[1:0] == 2'h0) && (idx < NMOD);

	assign waitrequest = req & ~ack_r;
	assign readdata    = {24'h000000, rdata_r};

	always @(posedge mclk) begin
		if (!resetn) begin
			ack_r   <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			ack_r <= req & ~ack_r;
			if (read & ~ack_r)
				rdata_r <= rd_mux;
		end
	end

	// ****************************************************************
	// Control state
	// ****************************************************************
	reg  [15:0]     cnt_r;
	reg             cr_r;
	reg             cf_r;
	reg  [NMOD-1:0] flag_r;
	reg             idle_stop_r;
	reg             wdt_en_r;
	reg  [2:0]      cps_r;
	reg             ecf_r;
	reg             arsel_r;
	reg             ecov_r;
	reg             covf_r;
	reg  [1:0]      cl_r;
	reg             moved_r;
	reg  [3:0]      div12_r;
	reg  [1:0]      div4_r;
	reg             ext_prev_r;
	reg  [10:0]     mask;

	wire wr_ctrl  = wr_go && (address == `CACW_ADDR_CTRL);
	wire wr_amode = wr_go && (address == `CACW_ADDR_AMODE);
	wire wr_pwm   = wr_go && (address == `CACW_ADDR_PWM);
	wire wr_cnt_l = wr_go && (address == `CACW_ADDR_CNT_L) && !wdt_en_r;
	wire wr_cnt_h = wr_go && (address == `CACW_ADDR_CNT_H) && !wdt_en_r;

	always @* begin
		case (cl_r)
		`CACW_CL_8:  mask = `CACW_MASK_8;
		`CACW_CL_9:  mask = `CACW_MASK_9;
		`CACW_CL_10: mask = `CACW_MASK_10;
		default:     mask = `CACW_MASK_11;
		endcase
	end

	// ****************************************************************
	// Counter clock source and tick
	// ****************************************************************
	wire div12_tick = (div12_r == `CACW_DIV12_LAST);
	wire div4_tick  = (div4_r == `CACW_DIV4_LAST);
	wire ext_tick   = ext_clk_in & ~ext_prev_r;
	reg  src_tick;

	always @* begin
		case (cps_r)
		`CACW_CPS_DIV12: src_tick = div12_tick;
		`CACW_CPS_DIV4:  src_tick = div4_tick;
		`CACW_CPS_TMR:   src_tick = timer_ovf_tick;
		`CACW_CPS_EXT:   src_tick = ext_tick;
		`CACW_CPS_SYS:   src_tick = 1'b1;
		default:         src_tick = slow_tick;
		endcase
	end

	wire run_eff = cr_r | wdt_en_r;
	wire tick    = run_eff & src_tick & ~(cpu_idle & idle_stop_r);
	wire wrap16  = tick && (cnt_r == `CACW_CNT_MAX);
	wire wrapn   = tick && ((cnt_r[10:0] & mask) == mask);

	always @(posedge mclk) begin
		if (!resetn) begin
			div12_r    <= 4'h0;
			div4_r     <= 2'h0;
			ext_prev_r <= 1'b0;
			moved_r    <= 1'b0;
			cnt_r      <= 16'h0000;
		end else begin
			div12_r    <= div12_tick ? 4'h0 : div12_r + 4'h1;
			div4_r     <= div4_r + 2'h1;
			ext_prev_r <= ext_clk_in;
			moved_r    <= tick;
			if (wr_cnt_l)
				cnt_r[7:0] <= wdata;
			else if (wr_cnt_h)
				cnt_r[15:8] <= wdata;
			else if (tick)
				cnt_r <= cnt_r + 16'h0001;
		end
	end

	// ****************************************************************
	// Capture/compare modules
	// ****************************************************************
	wire [NMOD*8-1:0]  mode_bus;
	wire [NMOD*8-1:0]  cpl_bus;
	wire [NMOD*8-1:0]  cph_bus;
	wire [NMOD*8-1:0]  arl_l_bus;
	wire [NMOD*8-1:0]  arl_h_bus;
	wire [NMOD-1:0]    match_v;
	wire [NMOD-1:0]    cap_v;
	wire [NMOD-1:0]    eccf_v;

	genvar i;
	generate
		for (i = 0; i < NMOD; i = i + 1) begin : g_mod
			reg  [7:0] mode_r;
			reg  [7:0] cpl_r;
			reg  [7:0] cph_r;
			reg  [7:0] arl_l_r;
			reg  [7:0] arl_h_r;
			wire       is_wdt  = (i == `CACW_WDT_MOD) && wdt_en_r;
			wire [7:0] mode_e  = is_wdt ?
				(mode_r & `CACW_WDT_MODE_MASK) : mode_r;
			wire       pwmn    = mode_e[`CACW_MD_PWM]
				& ~mode_e[`CACW_MD_TOG] & ~mode_e[`CACW_MD_PWM16];
			wire       hit_sel = wr_go && in_mods && (idx == i);
			wire       freq_step;
			wire [7:0] refresh = cnt_r[15:8] + cpl_r;

			always @(posedge mclk) begin
				if (!resetn) begin
					mode_r  <= 8'h00;
					cpl_r   <= 8'h00;
					cph_r   <= 8'h00;
					arl_l_r <= 8'h00;
					arl_h_r <= 8'h00;
				end else begin
					if (cap_v[i])
						{cph_r, cpl_r} <= cnt_r;
					else if (freq_step)
						cpl_r <= cpl_r + cph_r;
					else if (wrapn && pwmn)
						{cph_r, cpl_r} <= {arl_h_r, arl_l_r};
					if (hit_sel && region == `CACW_REGION_MODE && !is_wdt)
						mode_r <= wdata;
					if (hit_sel && region == `CACW_REGION_LOW) begin
						if (arsel_r)
							arl_l_r <= wdata;
						else
							cpl_r <= wdata;
					end
					if (hit_sel && region == `CACW_REGION_HIGH) begin
						if (is_wdt)
							cph_r <= refresh;
						else if (arsel_r)
							arl_h_r <= wdata;
						else
							cph_r <= wdata;
					end
				end
			end

			assign mode_bus[i*8 +: 8]  = mode_e;
			assign cpl_bus[i*8 +: 8]   = cpl_r;
			assign cph_bus[i*8 +: 8]   = cph_r;
			assign arl_l_bus[i*8 +: 8] = arl_l_r;
			assign arl_h_bus[i*8 +: 8] = arl_h_r;
			assign eccf_v[i]           = mode_e[`CACW_MD_ECCF];

			cacw_chan u_chan (
				.mclk      (mclk),
				.resetn    (resetn),
				.moved     (moved_r),
				.cnt       (cnt_r),
				.mask      (mask),
				.mode      (mode_e),
				.cmp       ({cph_r, cpl_r}),
				.pin_in    (module_pin_in[i]),
				.pin_out   (module_pin_out[i]),
				.pin_oe    (module_pin_oe[i]),
				.match     (match_v[i]),
				.capture   (cap_v[i]),
				.freq_step (freq_step)
			);
		end
	endgenerate

	// ****************************************************************
	// Flags and array configuration
	// ****************************************************************
	reg        wdt_fired_r;
	wire [7:0] wdt_cmp = cph_bus[`CACW_WDT_MOD*8 +: 8];
	wire       wdt_eq  = wdt_en_r & (cnt_r[15:8] == wdt_cmp);
	// One reset pulse per match episode: with a fast counter clock the
	// high bytes stay equal for many ticks, and the request must not
	// turn into a level
	wire       wdt_hit = wdt_eq & moved_r & ~wdt_fired_r;

	always @(posedge mclk) begin
		if (!resetn) begin
			cr_r           <= 1'b0;
			cf_r           <= 1'b0;
			flag_r         <= {NMOD{1'b0}};
			idle_stop_r    <= 1'b0;
			wdt_en_r       <= `CACW_WDT_RESET;
			cps_r          <= `CACW_CPS_DIV12;
			ecf_r          <= 1'b0;
			arsel_r        <= 1'b0;
			ecov_r         <= 1'b0;
			covf_r         <= 1'b0;
			cl_r           <= `CACW_CL_8;
			watchdog_reset <= 1'b0;
			wdt_fired_r    <= 1'b0;
		end else begin
			watchdog_reset <= wdt_hit;
			wdt_fired_r    <= wdt_eq & (wdt_fired_r | wdt_hit);
			// Hardware set wins over a same-cycle software clear
			flag_r <= (wr_ctrl ? wdata[NMOD-1:0] : flag_r)
				| match_v | cap_v;
			cf_r   <= (wr_ctrl ? wdata[`CACW_CTRL_CF] : cf_r) | wrap16;
			covf_r <= (wr_pwm ? wdata[`CACW_PWM_COVF] : covf_r) | wrapn;
			if (wr_ctrl)
				cr_r <= wdata[`CACW_CTRL_CR];
			if (wr_amode) begin
				wdt_en_r <= wdata[`CACW_AM_WDT];
				ecf_r    <= wdata[`CACW_AM_ECF];
				if (!wdt_en_r) begin
					idle_stop_r <= wdata[`CACW_AM_IDLE];
					cps_r <= wdata[`CACW_AM_CPS_HI:`CACW_AM_CPS_LO];
				end
			end
			if (wr_pwm) begin
				arsel_r <= wdata[`CACW_PWM_ARSEL];
				ecov_r  <= wdata[`CACW_PWM_ECOV];
				cl_r    <= wdata[`CACW_PWM_CL_HI:`CACW_PWM_CL_LO];
			end
		end
	end

	assign counter_array_irq = (cf_r & ecf_r)
		| (covf_r & ecov_r)
		| (|(flag_r & eccf_v));

	// ****************************************************************
	// Read multiplexer
	// ****************************************************************
	always @* begin
		rd_mux = 8'h00;
		case (address)
		`CACW_ADDR_CTRL: begin
			rd_mux = {cf_r, cr_r, 6'h00};
			rd_mux[NMOD-1:0] = flag_r;
		end
		`CACW_ADDR_AMODE:
			rd_mux = {idle_stop_r, wdt_en_r, 2'h0, cps_r, ecf_r};
		`CACW_ADDR_PWM:
			rd_mux = {arsel_r, ecov_r, covf_r, 3'h0, cl_r};
		`CACW_ADDR_CNT_L:
			rd_mux = cnt_r[7:0];
		`CACW_ADDR_CNT_H:
			rd_mux = cnt_r[15:8];
		default: begin
			if (in_mods) begin
				case (region)
				`CACW_REGION_MODE:
					rd_mux = mode_bus[idx*8 +: 8];
				`CACW_REGION_LOW:
					rd_mux = arsel_r ? arl_l_bus[idx*8 +: 8]
						: cpl_bus[idx*8 +: 8];
				`CACW_REGION_HIGH:
					rd_mux = arsel_r ? arl_h_bus[idx*8 +: 8]
						: cph_bus[idx*8 +: 8];
				default:
					rd_mux = 8'h00;
				endcase
			end
		end
		endcase
	end

endmodule
`default_nettype wire

// *** tb/cacw_pin_model.sv ***
// Far-side model driving the capture pins of the modules
`timescale 1ns/100ps
`default_nettype none
module cacw_pin_model (
	// Clock
	input  wire logic       mclk,
	// Requested levels and delay in cycles
	input  wire logic [5:0] target,
	input  wire logic [3:0] lag,
	// Pins
	output var  logic [5:0] pins
);
	logic [3:0] wait_r;
	initial begin
		pins   = 6'h00;
		wait_r = 4'h0;
	end
	// Follow the requested levels once lag cycles have passed
	always @(posedge mclk) begin
		if (pins == target)
			wait_r <= 4'h0;
		else if (wait_r >= lag)
			pins <= target;
		else
			wait_r <= wait_r + 4'h1;
	end
endmodule
`default_nettype wire

// *** tb/cacw_top_sva.sv ***
// Port assertions for the counter array top
`timescale 1ns/100ps
`default_nettype none
module cacw_top_sva #(
	parameter NMOD = 6
) (
	// Clock and reset
	input wire logic            mclk,
	input wire logic            resetn,
	// Register bus
	input wire logic [7:0]      address,
	input wire logic            read,
	input wire logic            write,
	input wire logic [31:0]     writedata,
	input wire logic [3:0]      byteenable,
	input wire logic [31:0]     readdata,
	input wire logic            waitrequest,
	// Sources and pins
	input wire logic            timer_ovf_tick,
	input wire logic            ext_clk_in,
	input wire logic            slow_tick,
	input wire logic            cpu_idle,
	input wire logic [NMOD-1:0] module_pin_in,
	input wire logic [NMOD-1:0] module_pin_out,
	input wire logic [NMOD-1:0] module_pin_oe,
	// Events
	input wire logic            counter_array_irq,
	input wire logic            watchdog_reset
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	chk_wait_first: assert property ($rose(read | write) |-> waitrequest)
		else $error("request answered without a wait cycle");
	chk_wait_once: assert property ((read | write) && waitrequest
		|=> !waitrequest) else $error("more than one wait cycle");
	chk_idle_nowait: assert property (!(read | write) |-> !waitrequest)
		else $error("wait raised while idle");
	chk_rd_upper: assert property (readdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	chk_unmapped_zero: assert property (read && waitrequest
		&& address == 8'hfc |=> readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_pulse_one: assert property (watchdog_reset |=> !watchdog_reset)
		else $error("reset request longer than one cycle");
	chk_wd_off: assert property (write && !waitrequest && address == 8'h04
		&& byteenable[0] && !writedata[6] |-> ##3 (!watchdog_reset)[*5])
		else $error("reset request while watchdog off");
	chk_rst_quiet: assert property ($rose(resetn)
		|-> (!watchdog_reset)[*8]) else $error("early reset request");
	cover property (watchdog_reset);
	cover property (read && !waitrequest);
	cover property (write && !waitrequest && address == 8'h74);
	cover property (module_pin_oe[4] && $rose(module_pin_out[4]));
endmodule
`default_nettype wire

// *** tb/tb_counter_array_capture_wdt.sv ***
// Self-checking bench for the counter array top
`timescale 1ns/100ps
`default_nettype none
module tb_counter_array_capture_wdt;
	localparam NMOD = 6;
	logic            mclk, resetn, read, write;
	logic [7:0]      address;
	logic [31:0]     writedata;
	logic [3:0]      byteenable;
	wire  [31:0]     readdata;
	wire             waitrequest, counter_array_irq, watchdog_reset;
	logic            timer_ovf_tick, ext_clk_in, slow_tick, cpu_idle;
	logic [NMOD-1:0] pin_target;
	logic [3:0]      pin_lag;
	wire  [NMOD-1:0] module_pin_in, module_pin_out, module_pin_oe;
	logic [7:0]      expq[$];
	int              n_errors, total_checks, n;
	cacw_top #(.NMOD(NMOD)) cacw_top_inst (.mclk, .resetn, .address,
		.read, .write, .writedata, .byteenable, .readdata, .waitrequest,
		.timer_ovf_tick, .ext_clk_in, .slow_tick, .cpu_idle,
		.module_pin_in, .module_pin_out, .module_pin_oe,
		.counter_array_irq, .watchdog_reset);
	cacw_pin_model cacw_pin_model_inst (.mclk, .target(pin_target),
		.lag(pin_lag), .pins(module_pin_in));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk)
		{timer_ovf_tick, ext_clk_in, slow_tick, cpu_idle} <= 4'($urandom());
	// ****************************************************************
	// Compare, bus and closing tasks
	// ****************************************************************
	task automatic check(input string w, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		logic [31:0] rnd;
		int          k;
		rnd = $urandom();
		k = 0;
		@(posedge mclk);
		address   <= a;
		read      <= !w;
		write     <= w;
		writedata <= {rnd[31:8], d};
		do begin
			@(posedge mclk);
			k++;
		end while (waitrequest !== 1'b0 && k < 20);
		read  <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0) begin
			n_errors++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		bus(1'b0, a, e);
	endtask
	always @(posedge mclk)
		if (read === 1'b1 && waitrequest === 1'b0 && expq.size() > 0)
			check($sformatf("read %h", address), expq.pop_front(),
				readdata[7:0]);
	initial begin
		void'($urandom(32'h2567));
		{resetn, read, write, address, writedata} = '0;
		{timer_ovf_tick, ext_clk_in, slow_tick, cpu_idle} = 4'h0;
		byteenable = 4'hf;
		pin_target = '0;
		pin_lag = 4'h0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		rd(8'h04, 8'h40);
		wr(8'h04, 8'h00);
		rd(8'h04, 8'h00);
		$display("test reset values done");
		wr(8'h04, 8'h08);
		wr(8'h0c, 8'h34);
		wr(8'h10, 8'h12);
		wr(8'h20, 8'h21);
		wr(8'h24, 8'h10);
		wr(8'h28, 8'h30);
		pin_target <= 6'h07;
		repeat (4) @(posedge mclk);
		rd(8'h00, 8'h05);
		check("irq", 8'h01, {7'h0, counter_array_irq});
		rd(8'h40, 8'h34);
		rd(8'h60, 8'h12);
		rd(8'h44, 8'h00);
		wr(8'h0c, 8'h56);
		pin_lag <= 4'h3;
		pin_target <= 6'h00;
		repeat (8) @(posedge mclk);
		rd(8'h00, 8'h07);
		rd(8'h44, 8'h56);
		rd(8'h48, 8'h56);
		rd(8'h40, 8'h34);
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h00);
		check("irq", 8'h00, {7'h0, counter_array_irq});
		wr(8'h08, 8'h80);
		wr(8'h4c, 8'haa);
		rd(8'h4c, 8'haa);
		wr(8'h08, 8'h00);
		rd(8'h4c, 8'h00);
		wr(8'hfc, 8'h5a);
		rd(8'hfc, 8'h00);
		$display("test capture done");
		wr(8'h4c, 8'h40);
		wr(8'h6c, 8'h13);
		wr(8'h50, 8'hff);
		wr(8'h2c, 8'h42);
		wr(8'h30, 8'h02);
		repeat (2) @(posedge mclk);
		check("pin oe", 8'h18, {2'h0, module_pin_oe});
		check("pin 8-bit", 8'h00, {2'h0, module_pin_out});
		wr(8'h08, 8'h01);
		repeat (2) @(posedge mclk);
		check("pin 9-bit", 8'h08, {2'h0, module_pin_out});
		wr(8'h08, 8'h00);
		wr(8'h2c, 8'hc2);
		repeat (2) @(posedge mclk);
		check("pin 16-bit", 8'h08, {2'h0, module_pin_out});
		wr(8'h70, 8'h12);
		wr(8'h50, 8'h60);
		wr(8'h30, 8'h4d);
		wr(8'h00, 8'h40);
		repeat (20) @(posedge mclk);
		rd(8'h00, 8'h50);
		check("irq", 8'h01, {7'h0, counter_array_irq});
		check("pin toggle", 8'h18, {2'h0, module_pin_out});
		wr(8'h00, 8'h00);
		$display("test compare done");
		wr(8'h10, 8'hf8);
		wr(8'h0c, 8'h00);
		wr(8'h54, 8'h10);
		wr(8'h04, 8'h48);
		wr(8'h74, 8'h00);
		rd(8'h74, 8'h08);
		wr(8'h10, 8'h00);
		rd(8'h10, 8'hf8);
		wr(8'h34, 8'hff);
		rd(8'h34, 8'h00);
		wr(8'h04, 8'hc0);
		rd(8'h04, 8'h48);
		wr(8'h00, 8'h00);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (watchdog_reset !== 1'b1 && n < 5000);
		check("wdt reset", 8'h01, {7'h0, watchdog_reset});
		check("wdt late", 8'h01, {7'h0, n > 3900});
		$display("test watchdog done");
		resetn <= 1'b0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		rd(8'h04, 8'h40);
		$display("test second reset done");
		end_of_test();
	end
endmodule
bind cacw_top cacw_top_sva #(.NMOD(NMOD)) cacw_top_sva_inst (.mclk,
	.resetn, .address, .read, .write, .writedata, .byteenable,
	.readdata, .waitrequest, .timer_ovf_tick, .ext_clk_in, .slow_tick,
	.cpu_idle, .module_pin_in, .module_pin_out, .module_pin_oe,
	.counter_array_irq, .watchdog_reset);
`default_nettype wire
